// file: inc/pcgp_regs.vh
// constants for the pixel colour / grey pipeline: apb register map and fields
// assumes a 32-bit apb slave with word-aligned registers on pclk
`ifndef PCGP_REGS_VH
`define PCGP_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define PCGP_CTRL_ADDR 12'h000
`define PCGP_MASK_ADDR 12'h004
`define PCGP_LUT_ADDR 12'h008
`define PCGP_LUT_DATA 12'h00c
`define PCGP_MAP_ADDR 12'h010
`define PCGP_MAP_DATA 12'h014
`define PCGP_CUR_CTRL 12'h018
`define PCGP_CUR_PAT 12'h01c
`define PCGP_CUR_PRI 12'h020
`define PCGP_CUR_SEC 12'h024
`define PCGP_CUR_AUX 12'h028
`define PCGP_CUR_ORG 12'h02c
`define PCGP_CUR_X 12'h030
`define PCGP_CUR_Y 12'h034
`define PCGP_STATUS 12'h038

// ************************************************************
// control register fields
// ************************************************************
`define PCGP_CTRL_MONO 0
`define PCGP_CTRL_PWM 1
`define PCGP_CTRL_HICOL 2
`define PCGP_CTRL_H565 3
`define PCGP_CTRL_TRUNC 4
`define PCGP_CTRL_ROUND 5
`define PCGP_CTRL_RESET 6'h00
`define PCGP_MASK_RESET 8'hff
`define PCGP_CUR_EN 0

// ************************************************************
// luminance weights in 1/256 units, cursor size
// ************************************************************
`define PCGP_W_RED 8'd77
`define PCGP_W_GRN 8'd151
`define PCGP_W_BLU 8'd28
`define PCGP_CUR_SIZE 7'd64

`endif

// file: core/pcgp_dither.v
// frame-rate plus spatial dither of one 6-bit shade to a 1-bit panel dot
// assumes frame_tick pulses once per frame and x/y are the pixel position
`timescale 1ns/1ps
module pcgp_dither (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pixel position and frame
    input wire frame_tick,
    input wire [1:0] x_lsb,
    input wire [1:0] y_lsb,
    // shade in, dot out
    input wire [5:0] shade,
    output reg dot
);
    reg [3:0] frame_cnt;
    wire [3:0] bayer;
    wire [5:0] thresh;

    // frame counter walks the temporal phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt <= 4'h0;
        end else if (frame_tick) begin
            frame_cnt <= frame_cnt + 4'h1;
        end
    end

    // 4x4 ordered pattern, offset per frame so each dot flickers rarely
    assign bayer = {x_lsb[0] ^ y_lsb[0], y_lsb[0], x_lsb[1] ^ y_lsb[1], y_lsb[1]};
    assign thresh = {bayer, frame_cnt[1:0]} + {frame_cnt[3:2], 4'h0};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dot <= 1'b0;
        end else begin
            dot <= (shade > thresh);
        end
    end
endmodule // pcgp_dither

// file: core/pcgp_pipeline.v
// pixel colour back end: palette, high colour, grey mapping, dither, cursor
// assumes pixel stream and display position arrive synchronous to pclk
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pcgp_regs.vh"
module pcgp_pipeline (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // pixel stream from attribute serializer
    input wire pix_valid,
    input wire [15:0] pix_data,
    input wire [10:0] pos_x,
    input wire [10:0] pos_y,
    input wire frame_start,
    input wire [10:0] win_w,
    input wire [10:0] win_h,
    // cursor fetch to sequencer
    output reg cur_req,
    output reg [19:0] cur_req_addr,
    input wire cur_ack,
    input wire [127:0] cur_row_data,
    // dac inputs
    output reg [5:0] dac_red,
    output reg [5:0] dac_grn,
    output reg [5:0] dac_blu,
    // panel data
    output reg [5:0] panel_grey,
    output reg [2:0] panel_dot,
    output reg [5:0] panel_red,
    output reg [5:0] panel_grn,
    output reg [5:0] panel_blu
);
    // ************************************************************
    // registers
    // ************************************************************
    reg [5:0] ctrl;
    reg [7:0] pix_mask;
    reg [9:0] lut_idx;
    reg [5:0] map_idx;
    reg cur_en;
    reg [19:0] cur_pat;
    reg [17:0] cur_pri;
    reg [17:0] cur_sec;
    reg [17:0] cur_aux;
    reg [11:0] cur_org;
    reg [10:0] cur_x;
    reg [10:0] cur_y;
    reg [5:0] lut_r [0:255];
    reg [5:0] lut_g [0:255];
    reg [5:0] lut_b [0:255];
    reg [5:0] map_ram [0:63];
    reg [127:0] cur_line;
    reg [5:0] row_fetch;
    wire apb_wr;
    wire apb_rd;
    wire [10:0] start_x;
    wire [10:0] start_y;

    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_rd = psel && !penable && !pwrite;

    // start position: display address less origin offset inside pattern
    assign start_x = cur_x - {5'h00, cur_org[5:0]};
    assign start_y = cur_y - {5'h00, cur_org[11:6]};

    // ************************************************************
    // apb write side; one wait-free access phase
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `PCGP_CTRL_RESET;
            pix_mask <= `PCGP_MASK_RESET;
            lut_idx <= 10'h000;
            map_idx <= 6'h00;
            cur_en <= 1'b0;
            cur_pat <= 20'h00000;
            cur_pri <= 18'h00000;
            cur_sec <= 18'h00000;
            cur_aux <= 18'h00000;
            cur_org <= 12'h000;
            cur_x <= 11'h000;
            cur_y <= 11'h000;
        end else if (apb_wr) begin
            case (paddr)
                `PCGP_CTRL_ADDR: ctrl <= pwdata[5:0];
                `PCGP_MASK_ADDR: pix_mask <= pwdata[7:0];
                `PCGP_LUT_ADDR: lut_idx <= pwdata[9:0];
                `PCGP_LUT_DATA: lut_idx <= lut_idx + 10'h001; // auto-step per word
                `PCGP_MAP_ADDR: map_idx <= pwdata[5:0];
                `PCGP_MAP_DATA: map_idx <= map_idx + 6'h01;
                `PCGP_CUR_CTRL: cur_en <= pwdata[`PCGP_CUR_EN];
                `PCGP_CUR_PAT: cur_pat <= pwdata[19:0];
                `PCGP_CUR_PRI: cur_pri <= pwdata[17:0];
                `PCGP_CUR_SEC: cur_sec <= pwdata[17:0];
                `PCGP_CUR_AUX: cur_aux <= pwdata[17:0];
                `PCGP_CUR_ORG: cur_org <= pwdata[11:0];
                `PCGP_CUR_X: cur_x <= pwdata[10:0];
                `PCGP_CUR_Y: cur_y <= pwdata[10:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // table storage; no reset, software loads them after clock settles
    always @(posedge pclk) begin
        if (apb_wr && paddr == `PCGP_LUT_DATA) begin
            case (lut_idx[9:8])
                2'h0: lut_r[lut_idx[7:0]] <= pwdata[5:0];
                2'h1: lut_g[lut_idx[7:0]] <= pwdata[5:0];
                default: lut_b[lut_idx[7:0]] <= pwdata[5:0];
            endcase
        end
        if (apb_wr && paddr == `PCGP_MAP_DATA) begin
            map_ram[map_idx] <= pwdata[5:0];
        end
    end

    // ************************************************************
    // apb read side and answer
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable; // answer in the first access cycle
            pslverr <= psel && !penable && (paddr > `PCGP_STATUS || paddr[1:0] != 2'h0);
            if (apb_rd) begin
                case (paddr)
                    `PCGP_CTRL_ADDR: prdata <= {26'h0, ctrl};
                    `PCGP_MASK_ADDR: prdata <= {24'h0, pix_mask};
                    `PCGP_LUT_ADDR: prdata <= {22'h0, lut_idx};
                    `PCGP_MAP_ADDR: prdata <= {26'h0, map_idx};
                    `PCGP_CUR_CTRL: prdata <= {31'h0, cur_en};
                    `PCGP_CUR_PAT: prdata <= {12'h0, cur_pat};
                    `PCGP_CUR_PRI: prdata <= {14'h0, cur_pri};
                    `PCGP_CUR_SEC: prdata <= {14'h0, cur_sec};
                    `PCGP_CUR_AUX: prdata <= {14'h0, cur_aux};
                    `PCGP_CUR_ORG: prdata <= {20'h0, cur_org};
                    `PCGP_CUR_X: prdata <= {21'h0, cur_x};
                    `PCGP_CUR_Y: prdata <= {21'h0, cur_y};
                    `PCGP_STATUS: prdata <= {25'h0, cur_req, row_fetch};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************************
    // stage 1: palette or high-colour split
    // ************************************************************
    reg [5:0] s1_r;
    reg [5:0] s1_g;
    reg [5:0] s1_b;
    reg s1_v;
    reg [10:0] s1_x;
    reg [10:0] s1_y;
    wire [7:0] lut_index;

    assign lut_index = pix_data[7:0] & pix_mask;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 6'h00;
            s1_g <= 6'h00;
            s1_b <= 6'h00;
            s1_v <= 1'b0;
            s1_x <= 11'h000;
            s1_y <= 11'h000;
        end else begin
            s1_v <= pix_valid;
            s1_x <= pos_x;
            s1_y <= pos_y;
            if (ctrl[`PCGP_CTRL_HICOL] && ctrl[`PCGP_CTRL_H565]) begin
                // bypass tables 565 split, red and blue lsb zero
                s1_r <= {pix_data[15:11], 1'b0};
                s1_g <= pix_data[10:5];
                s1_b <= {pix_data[4:0], 1'b0};
            end else if (ctrl[`PCGP_CTRL_HICOL]) begin
                // 555 split, top bit ignored, all lsbs zero
                s1_r <= {pix_data[14:10], 1'b0};
                s1_g <= {pix_data[9:5], 1'b0};
                s1_b <= {pix_data[4:0], 1'b0};
            end else begin
                s1_r <= lut_r[lut_index];
                s1_g <= lut_g[lut_index];
                s1_b <= lut_b[lut_index];
            end
        end
    end

    // ************************************************************
    // grey weighting and shade selection
    // ************************************************************
    wire [15:0] grey_sum;
    wire [5:0] grey6;
    wire [6:0] grey_rnd;
    wire [5:0] grey_pwm;

    // weights sum to 256, so the top byte is the 6-bit grey
    assign grey_sum = s1_r * `PCGP_W_RED + s1_g * `PCGP_W_GRN + s1_b * `PCGP_W_BLU;
    assign grey6 = grey_sum[13:8];
    assign grey_rnd = {1'b0, grey6} + {6'h00, grey_sum[7]};
    // rounding saturates at full white rather than wrapping
    assign grey_pwm = ctrl[`PCGP_CTRL_ROUND] ? (grey_rnd[6] ? 6'h3f : grey_rnd[5:0]) : grey6;

    // ************************************************************
    // cursor fetch: one row request per line via the sequencer
    // ************************************************************
    wire line_hit;
    assign line_hit = cur_en && pos_x == 11'h000 && pix_valid
        && pos_y >= start_y && pos_y < start_y + {4'h0, `PCGP_CUR_SIZE};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_req <= 1'b0;
            cur_req_addr <= 20'h00000;
            cur_line <= 128'h0;
            row_fetch <= 6'h00;
        end else if (cur_req && cur_ack) begin
            cur_req <= 1'b0;
            cur_line <= cur_row_data;
        end else if (line_hit && !cur_req) begin
            row_fetch <= pos_y[5:0] - start_y[5:0];
            cur_req <= 1'b1;
            // 16 bytes per pattern row from the pattern base
            cur_req_addr <= cur_pat + {10'h000, pos_y[5:0] - start_y[5:0], 4'h0};
        end
    end

    // ************************************************************
    // stage 2: cursor merge, clipping and output
    // ************************************************************
    wire [10:0] rel_x;
    wire in_cur;
    wire in_win;
    reg [1:0] ccode;
    reg [17:0] mix;
    wire [2:0] dots;

    assign rel_x = s1_x - start_x;
    assign in_win = s1_x < win_w && s1_y < win_h;
    assign in_cur = cur_en && s1_x >= start_x && rel_x < {4'h0, `PCGP_CUR_SIZE}
        && s1_y >= start_y && s1_y - start_y < {4'h0, `PCGP_CUR_SIZE} && in_win;

    // code select: 0 transparent, 1 primary, 2 secondary, 3 auxiliary
    always @* begin
        ccode = in_cur ? cur_line[{rel_x[5:0], 1'b0} +: 2] : 2'h0;
        case (ccode)
            2'h1: mix = cur_pri;
            2'h2: mix = cur_sec;
            2'h3: mix = cur_aux;
            default: mix = {s1_r, s1_g, s1_b};
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_dith
            // per-channel dither; mono feeds the mapped grey to all three lanes
            pcgp_dither u_dither (
                .pclk(pclk),
                .presetn(presetn),
                .frame_tick(frame_start),
                .x_lsb(s1_x[1:0]),
                .y_lsb(s1_y[1:0]),
                .shade(ctrl[`PCGP_CTRL_MONO] ? map_ram[grey6] : mix[17 - 6 * gi -: 6]),
                .dot(dots[gi])
            );
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_red <= 6'h00;
            dac_grn <= 6'h00;
            dac_blu <= 6'h00;
            panel_grey <= 6'h00;
            panel_dot <= 3'h0;
            panel_red <= 6'h00;
            panel_grn <= 6'h00;
            panel_blu <= 6'h00;
        end else begin
            dac_red <= mix[17:12];
            dac_grn <= mix[11:6];
            dac_blu <= mix[5:0];
            panel_dot <= dots;
            if (ctrl[`PCGP_CTRL_PWM]) begin
                panel_grey <= grey_pwm;
            end else begin
                panel_grey <= map_ram[grey6];
            end
            if (ctrl[`PCGP_CTRL_TRUNC]) begin
                // truncated colour keeps the top four bits
                panel_red <= {mix[17:14], 2'h0};
                panel_grn <= {mix[11:8], 2'h0};
                panel_blu <= {mix[5:2], 2'h0};
            end else begin
                panel_red <= mix[17:12];
                panel_grn <= mix[11:6];
                panel_blu <= mix[5:0];
            end
        end
    end
endmodule // pcgp_pipeline

// file: test/pcgp_chk.sv
// checker for the pixel colour pipeline: apb answer, high colour path, cursor fetch
// assumes it is bound to pcgp_pipeline and sees only that module's ports
`timescale 1ns/1ps
`include "pcgp_regs.vh"
module pcgp_chk (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pixel and cursor fetch
    input wire pix_valid,
    input wire [15:0] pix_data,
    input wire cur_req,
    input wire [19:0] cur_req_addr,
    input wire cur_ack,
    // dac inputs
    input wire [5:0] dac_red,
    input wire [5:0] dac_grn,
    input wire [5:0] dac_blu
);
    // ************************************************************
    // shadow of control bits, taken from completed apb writes
    // ************************************************************
    reg [5:0] ctrl_q;
    reg cur_en_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 6'h00;
            cur_en_q <= 1'b0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == `PCGP_CTRL_ADDR) ctrl_q <= pwdata[5:0];
            if (paddr == `PCGP_CUR_CTRL) cur_en_q <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ************************************************************
    // sequences and assertions
    // ************************************************************
    sequence s_setup;
        psel && !penable;
    endsequence
    // cursor off so overlay cannot hide the colour path
    sequence s_hicol;
        pix_valid && ctrl_q[2] && !ctrl_q[0] && !cur_en_q;
    endsequence
    a_apb_answer: assert property (s_setup |=> pready)
        else $error("pready missing in access cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held over two cycles");
    a_slverr_map: assert property (psel && penable && pready |->
        pslverr == (paddr > `PCGP_STATUS || paddr[1:0] != 2'b00))
        else $error("pslverr does not match address map");
    a_err_rdzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_hicol_565: assert property (s_hicol ##0 ctrl_q[3] |-> ##2
        (dac_red == {$past(pix_data[15:11], 2), 1'b0} && dac_grn == $past(pix_data[10:5], 2)
        && dac_blu == {$past(pix_data[4:0], 2), 1'b0}))
        else $error("565 pixel not split onto dacs");
    a_hicol_555: assert property (s_hicol ##0 !ctrl_q[3] |-> ##2
        (dac_red == {$past(pix_data[14:10], 2), 1'b0} && dac_grn == {$past(pix_data[9:5], 2), 1'b0}
        && dac_blu == {$past(pix_data[4:0], 2), 1'b0}))
        else $error("555 pixel not split onto dacs");
    a_fetch_hold: assert property (cur_req && !cur_ack |=> cur_req && $stable(cur_req_addr))
        else $error("cursor fetch dropped before answer");
    a_fetch_release: assert property (cur_req && cur_ack |=> !cur_req)
        else $error("cursor fetch held after answer");
endmodule // pcgp_chk

bind pcgp_pipeline pcgp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_data(pix_data),
    .cur_req(cur_req), .cur_req_addr(cur_req_addr), .cur_ack(cur_ack),
    .dac_red(dac_red), .dac_grn(dac_grn), .dac_blu(dac_blu));

// file: test/pcgp_seq_model.sv
// stand-in for the memory sequencer answering cursor pattern fetches
// assumes the pipeline holds cur_req until it sees cur_ack
`timescale 1ns/1ps
module pcgp_seq_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // fetch handshake
    input wire cur_req,
    input wire [3:0] latency,
    input wire [127:0] row_pattern,
    output reg cur_ack,
    output reg [127:0] cur_row_data
);
    reg [3:0] wait_cnt;
    // answer after latency cycles with a one-cycle ack; off the ack the
    // data lines toggle so a stale row can never look valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ack <= 1'b0;
            wait_cnt <= 4'h0;
            cur_row_data <= 128'h0;
        end else if (cur_req && !cur_ack && wait_cnt == latency) begin
            cur_ack <= 1'b1;
            wait_cnt <= 4'h0;
            cur_row_data <= row_pattern;
        end else begin
            cur_ack <= 1'b0;
            wait_cnt <= (cur_req && !cur_ack) ? wait_cnt + 4'h1 : 4'h0;
            cur_row_data <= ~cur_row_data;
        end
    end
endmodule // pcgp_seq_model

// file: test/testbench.sv
// self-checking bench for the pixel colour pipeline
// assumes one 100 mhz clock and the sequencer model on the fetch port
`timescale 1ns/1ps
`include "pcgp_regs.vh"
module testbench;
    // ************************************************************
    // signals
    // ************************************************************
    reg pclk, presetn, psel, penable, pwrite, pix_valid, frm;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [15:0] pix_data;
    reg [10:0] pos_x, pos_y;
    reg err;
    reg [17:0] got;
    wire [31:0] prdata;
    wire pready, pslverr, cur_req, cur_ack;
    wire [19:0] cur_req_addr;
    wire [127:0] cur_row_data;
    wire [5:0] dac_red, dac_grn, dac_blu, panel_grey, panel_red, panel_grn, panel_blu;
    wire [2:0] panel_dot;
    integer num_errors, samples_checked, i, n;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [7:0] mask;
        logic [15:0] pix;
        logic [1:0] what;
        logic [17:0] exp;
    } pcgp_row_t;
    pcgp_row_t rows [0:15];
    reg [15:0] lut_tab [0:5];
    reg [17:0] cur_exp [1:4];
    pcgp_pipeline uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_valid(pix_valid), .pix_data(pix_data), .pos_x(pos_x),
        .pos_y(pos_y), .frame_start(frm), .win_w(11'd640), .win_h(11'd480),
        .cur_req(cur_req), .cur_req_addr(cur_req_addr), .cur_ack(cur_ack),
        .cur_row_data(cur_row_data), .dac_red(dac_red), .dac_grn(dac_grn), .dac_blu(dac_blu),
        .panel_grey(panel_grey), .panel_dot(panel_dot), .panel_red(panel_red),
        .panel_grn(panel_grn), .panel_blu(panel_blu));
    // slow answer so the held request can be seen
    pcgp_seq_model seq (.pclk(pclk), .presetn(presetn), .cur_req(cur_req), .latency(4'd9),
        .row_pattern(128'he4), .cur_ack(cur_ack), .cur_row_data(cur_row_data));
    // ************************************************************
    // tasks
    // ************************************************************
    task conclude;
        begin
            if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // setup, access held until pready, release after that edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n == 20) begin
                num_errors = num_errors + 1;
                conclude;
            end
        end
    endtask
    // one qualified pixel; returns one step after its outputs land
    task pixel(input logic [15:0] d, input logic [10:0] x, input logic [10:0] y);
        begin
            @(posedge pclk);
            pix_valid <= 1'b1;
            pix_data <= d;
            pos_x <= x;
            pos_y <= y;
            @(posedge pclk);
            pix_valid <= 1'b0;
            repeat (2) @(posedge pclk);
            #1;
        end
    endtask
    // ************************************************************
    // clock and main sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, pix_valid, frm} = 6'h00;
        {paddr, pwdata, pix_data, pos_x, pos_y} = 82'h0;
        num_errors = 0;
        samples_checked = 0;
        rows[0] = '{6'h04, 8'hff, 16'hfc00, 2'd0, {6'h3e, 6'h00, 6'h00}};
        rows[1] = '{6'h04, 8'hff, 16'h03e0, 2'd0, {6'h00, 6'h3e, 6'h00}};
        rows[2] = '{6'h04, 8'hff, 16'h001f, 2'd0, {6'h00, 6'h00, 6'h3e}};
        rows[3] = '{6'h0c, 8'hff, 16'hf800, 2'd0, {6'h3e, 6'h00, 6'h00}};
        rows[4] = '{6'h0c, 8'hff, 16'h07e0, 2'd0, {6'h00, 6'h3f, 6'h00}};
        rows[5] = '{6'h0c, 8'hff, 16'h0821, 2'd0, {6'h02, 6'h01, 6'h02}};
        rows[6] = '{6'h00, 8'hff, 16'h005a, 2'd0, {6'h3f, 6'h00, 6'h00}};
        rows[7] = '{6'h00, 8'hff, 16'hff0a, 2'd0, {6'h01, 6'h2a, 6'h15}};
        rows[8] = '{6'h00, 8'h0f, 16'h005a, 2'd0, {6'h01, 6'h2a, 6'h15}};
        rows[9] = '{6'h01, 8'hff, 16'h005a, 2'd1, {12'h000, 6'h2d}};
        rows[10] = '{6'h03, 8'hff, 16'h005a, 2'd1, {12'h000, 6'h12}};
        rows[11] = '{6'h02, 8'hff, 16'h000a, 2'd2, {6'h01, 6'h2a, 6'h15}};
        // rounding carries the half bit of grey 18 up to 19
        rows[12] = '{6'h23, 8'hff, 16'h005a, 2'd1, {12'h000, 6'h13}};
        rows[13] = '{6'h12, 8'hff, 16'h000a, 2'd2, {6'h00, 6'h28, 6'h14}};
        // dots at x 5, y 100, frame 0: threshold 32 on every lane
        rows[14] = '{6'h01, 8'hff, 16'h005a, 2'd3, 18'h00007};
        rows[15] = '{6'h00, 8'hff, 16'h000a, 2'd3, 18'h00002};
        lut_tab[0] = {2'd0, 8'h5a, 6'h3f};
        lut_tab[1] = {2'd1, 8'h5a, 6'h00};
        lut_tab[2] = {2'd2, 8'h5a, 6'h00};
        lut_tab[3] = {2'd0, 8'h0a, 6'h01};
        lut_tab[4] = {2'd1, 8'h0a, 6'h2a};
        lut_tab[5] = {2'd2, 8'h0a, 6'h15};
        cur_exp[1] = 18'h3f001;
        cur_exp[2] = 18'h00fc2;
        cur_exp[3] = 18'h15a83;
        cur_exp[4] = {6'h3e, 6'h3f, 6'h3e};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check("dac after reset", 32'h0, {14'h0, dac_red, dac_grn, dac_blu});
        apb(1'b0, `PCGP_CTRL_ADDR, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b0, `PCGP_MASK_ADDR, 32'h0);
        check("mask reset", 32'hff, rd);
        apb(1'b0, 12'h040, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        // grey 18 lands on the second of two auto-incremented map writes
        for (i = 0; i < 6; i = i + 1) begin
            apb(1'b1, `PCGP_LUT_ADDR, {22'h0, lut_tab[i][15:6]});
            apb(1'b1, `PCGP_LUT_DATA, {26'h0, lut_tab[i][5:0]});
        end
        apb(1'b1, `PCGP_MAP_ADDR, 32'd17);
        apb(1'b1, `PCGP_MAP_DATA, 32'h11);
        apb(1'b1, `PCGP_MAP_DATA, 32'h2d);
        for (i = 0; i < 16; i = i + 1) begin
            apb(1'b1, `PCGP_CTRL_ADDR, {26'h0, rows[i].ctrl});
            apb(1'b1, `PCGP_MASK_ADDR, {24'h0, rows[i].mask});
            pixel(rows[i].pix, 11'd5, 11'd100);
            got = (rows[i].what == 2'd0) ? {dac_red, dac_grn, dac_blu} :
                (rows[i].what == 2'd1) ? {12'h000, panel_grey} :
                (rows[i].what == 2'd2) ? {panel_red, panel_grn, panel_blu} : {15'h0, panel_dot};
            check("pixel row", {14'h0, rows[i].exp}, {14'h0, got});
        end
        // four frames raise the threshold to 48, above mapped shade 45
        repeat (4) begin
            @(posedge pclk);
            frm <= 1'b1;
            @(posedge pclk);
            frm <= 1'b0;
        end
        apb(1'b1, `PCGP_CTRL_ADDR, 32'h01);
        pixel(16'h005a, 11'd5, 11'd100);
        check("frame dot", 32'h0, {29'h0, panel_dot});
        // cursor: origin and display address zero, so pattern pixel n sits at x n
        apb(1'b1, `PCGP_CTRL_ADDR, 32'h0c);
        apb(1'b1, `PCGP_CUR_PRI, {14'h0, cur_exp[1]});
        apb(1'b1, `PCGP_CUR_SEC, {14'h0, cur_exp[2]});
        apb(1'b1, `PCGP_CUR_AUX, {14'h0, cur_exp[3]});
        apb(1'b1, `PCGP_CUR_PAT, 32'h12340);
        apb(1'b1, `PCGP_CUR_CTRL, 32'h1);
        pixel(16'h0000, 11'd0, 11'd0);
        check("fetch request", {11'h0, 1'b1, 20'h12340}, {11'h0, cur_req, cur_req_addr});
        n = 0;
        while (cur_req !== 1'b0 && n < 40) begin
            n = n + 1;
            @(posedge pclk);
        end
        check("fetch answered", 32'h0, {31'h0, cur_req});
        for (i = 1; i < 5; i = i + 1) begin
            pixel(16'hffff, i[10:0], 11'd0);
            check("cursor pixel", {14'h0, cur_exp[i]}, {14'h0, dac_red, dac_grn, dac_blu});
        end
        conclude;
    end
endmodule // testbench
